// ### core/tx_cmd_defines.vh
`ifndef TX_CMD_DEFINES_VH
`define TX_CMD_DEFINES_VH

// command word a field positions
`define CMDA_IOC_BIT 31
`define CMDA_ALIGN_HI 25
`define CMDA_ALIGN_LO 24
`define CMDA_OFS_HI 20
`define CMDA_OFS_LO 16
`define CMDA_SIZE_HI 10
`define CMDA_SIZE_LO 0

// end alignment codes
`define ALIGN_4B 2'h0
`define ALIGN_16B 2'h1
`define ALIGN_32B 2'h2
`define ALIGN_RSVD 2'h3

// register byte offsets
`define REG_STATUS 6'h00
`define REG_INT_CLR 6'h04
`define REG_INT_EN 6'h08
`define REG_CTRL 6'h0C
`define REG_CMD_VIEW 6'h10
`define REG_PROGRESS 6'h14

// status, clear and enable bit positions
`define ST_DONE_BIT 0
`define ST_ERR_BIT 1
`define CTRL_ENABLE_BIT 0

// reset values and bus codes
`define CTRL_RESET 1'h1
`define INT_EN_RESET 2'h0
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2

// one-hot states
`define ST_CMDA 3'h1
`define ST_CMDB 3'h2
`define ST_BODY 3'h4

`endif

// ### core/dword_plan.v
`include "tx_cmd_defines.vh"

module dword_plan (
	// buffer description
	input wire [10:0] size,
	input wire [4:0] offset,
	input wire [1:0] align,
	// word plan
	output reg [9:0] data_dw,
	output reg [9:0] total_dw,
	output wire [2:0] first_dw,
	output wire [3:0] first_be,
	output wire [3:0] last_be
);

	reg [11:0] end_b;
	reg [11:0] end_rnd;
	reg [11:0] end_m1;

	// byte lanes from lo upward to hi
	function [3:0] lane_mask;
		input [1:0] lo;
		input [1:0] hi;
		integer i;
		begin
			lane_mask = 4'h0;
			for (i = 0; i < 4; i = i + 1) begin
				lane_mask[i] = (i >= lo) && (i <= hi);
			end
		end
	endfunction

	always @* begin
		end_b = {1'b0, size} + {7'h00, offset};
		end_rnd = end_b + 12'h003;
		end_m1 = end_b - 12'h001;
		data_dw = (size == 11'h000) ? 10'h000 : end_rnd[11:2];
		case (align)
			`ALIGN_16B: total_dw = (data_dw + 10'h003) & 10'h3FC;
			`ALIGN_32B: total_dw = (data_dw + 10'h007) & 10'h3F8;
			default: total_dw = data_dw;
		endcase
	end

	assign first_dw = offset[4:2];
	assign first_be = lane_mask(offset[1:0], 2'h3);
	assign last_be = lane_mask(2'h0, end_m1[1:0]);

endmodule // dword_plan

// ### core/tx_command_a_decoder.v
// Summary of operation
// - a buffer whose command word has bit 31 set raises the done flag once its last word is taken in.
// - the done flag reaches the interrupt output only while its enable bit is set by software.
// - alignment code 00, 01, 10 selects a 4, 16 or 32 byte end boundary; 11 is reserved.
// - filler words after the payload are swallowed and never reach the payload output.
// - the eleven-bit size field with the offset field and the alignment code sets how many words and filler words follow.
//
// Our own choices: the register addresses and register access over AHB-Lite.
`include "tx_cmd_defines.vh"

module tx_command_a_decoder (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// word stream from host bus
	input wire in_valid,
	input wire [31:0] in_data,
	output wire in_ready,
	// payload stream to tx fifo
	output reg out_valid,
	output reg [31:0] out_data,
	output reg [3:0] out_be,
	output reg out_last,
	input wire out_ready,
	// interrupt
	output wire irq
);

	//////////////////////////////////////////////////////////////////////
	// state and command fields
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg ioc_q;
	reg [1:0] align_q;
	reg [4:0] ofs_q;
	reg [10:0] size_q;
	reg [9:0] idx_q;
	reg [9:0] data_dw_q;
	reg [9:0] total_dw_q;
	reg [2:0] first_dw_q;
	reg [3:0] first_be_q;
	reg [3:0] last_be_q;
	reg [31:0] cmd_view_q;

	wire [9:0] plan_data_dw;
	wire [9:0] plan_total_dw;
	wire [2:0] plan_first_dw;
	wire [3:0] plan_first_be;
	wire [3:0] plan_last_be;

	// register file
	reg [1:0] status_q;
	reg [1:0] int_en_q;
	reg ctrl_en_q;

	// ahb address phase capture
	reg wr_pend_q;
	reg [5:0] wr_addr_q;

	//////////////////////////////////////////////////////////////////////
	// word plan for the buffer just described
	dword_plan u_plan (
		.size(size_q),
		.offset(ofs_q),
		.align(align_q),
		.data_dw(plan_data_dw),
		.total_dw(plan_total_dw),
		.first_dw(plan_first_dw),
		.first_be(plan_first_be),
		.last_be(plan_last_be)
	);

	//////////////////////////////////////////////////////////////////////
	// stream handshake
	wire in_body = (state_q == `ST_BODY);
	wire is_payload = in_body && (idx_q >= {7'h00, first_dw_q}) && (idx_q < data_dw_q);
	wire out_free = !out_valid || out_ready;
	assign in_ready = ctrl_en_q && (!is_payload || out_free);
	wire take = in_valid && in_ready;
	wire body_end = in_body && take && (idx_q == total_dw_q - 10'h001);
	wire bad_align = (in_data[`CMDA_ALIGN_HI:`CMDA_ALIGN_LO] == `ALIGN_RSVD);
	wire empty_buf = (plan_total_dw == 10'h000);

	always @* begin
		state_d = state_q;
		case (state_q)
			`ST_CMDA: begin
				if (take)
					state_d = `ST_CMDB;
			end
			`ST_CMDB: begin
				if (take)
					state_d = empty_buf ? `ST_CMDA : `ST_BODY;
			end
			`ST_BODY: begin
				if (body_end)
					state_d = `ST_CMDA;
			end
			default: state_d = `ST_CMDA;
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// command capture and word counting
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= `ST_CMDA;
			ioc_q <= 1'b0;
			align_q <= `ALIGN_4B;
			ofs_q <= 5'h00;
			size_q <= 11'h000;
			idx_q <= 10'h000;
			data_dw_q <= 10'h000;
			total_dw_q <= 10'h000;
			first_dw_q <= 3'h0;
			first_be_q <= 4'h0;
			last_be_q <= 4'h0;
			cmd_view_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			if (state_q == `ST_CMDA && take) begin
				ioc_q <= in_data[`CMDA_IOC_BIT];
				align_q <= bad_align ? `ALIGN_4B : in_data[`CMDA_ALIGN_HI:`CMDA_ALIGN_LO];
				ofs_q <= in_data[`CMDA_OFS_HI:`CMDA_OFS_LO];
				size_q <= in_data[`CMDA_SIZE_HI:`CMDA_SIZE_LO];
				cmd_view_q <= in_data;
			end
			if (state_q == `ST_CMDB && take) begin
				data_dw_q <= plan_data_dw;
				total_dw_q <= plan_total_dw;
				first_dw_q <= plan_first_dw;
				first_be_q <= plan_first_be;
				last_be_q <= plan_last_be;
				idx_q <= 10'h000;
			end else if (in_body && take) begin
				idx_q <= idx_q + 10'h001;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// payload output register
	wire [3:0] cur_be = ((idx_q == {7'h00, first_dw_q}) ? first_be_q : 4'hF) &
		((idx_q == data_dw_q - 10'h001) ? last_be_q : 4'hF);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_valid <= 1'b0;
			out_data <= 32'h0000_0000;
			out_be <= 4'h0;
			out_last <= 1'b0;
		end else if (is_payload && take) begin
			out_valid <= 1'b1;
			out_data <= in_data;
			out_be <= cur_be;
			out_last <= (idx_q == data_dw_q - 10'h001);
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// events
	wire ev_done = (body_end && ioc_q) || (state_q == `ST_CMDB && take && empty_buf && ioc_q);
	wire ev_err = (state_q == `ST_CMDA) && take && bad_align;

	//////////////////////////////////////////////////////////////////////
	// ahb-lite slave
	wire acc = hsel && hready && (htrans == `HTRANS_NONSEQ) && (hsize == `HSIZE_WORD);
	wire [1:0] clr_bits = (wr_pend_q && wr_addr_q == `REG_INT_CLR) ? hwdata[1:0] : 2'h0;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 6'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend_q <= acc && hwrite && (haddr[7:6] == 2'h0);
			wr_addr_q <= haddr[5:0];
			hrdata <= 32'h0000_0000;
			if (acc && !hwrite) begin
				case (haddr[7:0])
					{2'h0, `REG_STATUS}: hrdata <= {30'h0000_0000, status_q};
					{2'h0, `REG_INT_EN}: hrdata <= {30'h0000_0000, int_en_q};
					{2'h0, `REG_CTRL}: hrdata <= {31'h0000_0000, ctrl_en_q};
					{2'h0, `REG_CMD_VIEW}: hrdata <= cmd_view_q;
					{2'h0, `REG_PROGRESS}: hrdata <= {19'h0_0000, state_q, idx_q};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// sticky status, enables and control
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= 2'h0;
			int_en_q <= `INT_EN_RESET;
			ctrl_en_q <= `CTRL_RESET;
		end else begin
			status_q[`ST_DONE_BIT] <= ev_done | (status_q[`ST_DONE_BIT] & ~clr_bits[`ST_DONE_BIT]);
			status_q[`ST_ERR_BIT] <= ev_err | (status_q[`ST_ERR_BIT] & ~clr_bits[`ST_ERR_BIT]);
			if (wr_pend_q && wr_addr_q == `REG_INT_EN)
				int_en_q <= hwdata[1:0];
			if (wr_pend_q && wr_addr_q == `REG_CTRL)
				ctrl_en_q <= hwdata[`CTRL_ENABLE_BIT];
		end
	end

	assign irq = |(status_q & int_en_q);

endmodule // tx_command_a_decoder

// ### verification/tx_command_a_decoder_monitor.sv
module tx_command_a_decoder_monitor (
	// watched ports
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire in_valid,
	input wire in_ready,
	input wire out_valid,
	input wire [31:0] out_data,
	input wire [3:0] out_be,
	input wire out_last,
	input wire out_ready,
	input wire irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_stall;
		out_valid && !out_ready;
	endsequence
	a_out_hold: assert property (s_stall |=> out_valid && $stable(out_data) && $stable(out_be))
		else $error("payload changed while stalled");
	a_out_cause: assert property (out_valid && !$past(out_valid && !out_ready) |-> $past(in_valid && in_ready))
		else $error("payload word without a taken word");
	a_be_contig: assert property (out_valid |-> out_be inside {1, 2, 3, 4, 6, 7, 8, 12, 14, 15})
		else $error("byte enables not contiguous");
	a_be_upper: assert property (out_valid && !out_last |-> out_be[3])
		else $error("inner word lacks top lane");
	a_irq_rise: assert property ($rose(irq) |-> $past(in_valid && in_ready) ||
		$past(hsel && htrans == 2'h2 && hwrite, 2))
		else $error("interrupt rose without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(hsel && htrans == 2'h2 && hwrite, 2))
		else $error("interrupt fell without a write");
	a_rd_idle: assert property (!$past(hsel && htrans == 2'h2 && !hwrite) |-> hrdata == 32'h0000_0000)
		else $error("read data outside data phase");
	a_resp_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
endmodule // tx_command_a_decoder_monitor

// ### verification/host_writer.sv
module host_writer (
	// word stream
	input wire hclk,
	input wire hresetn,
	input wire in_ready,
	output logic in_valid,
	output logic [31:0] in_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] q[$];
	initial begin
		in_valid = 1'b0;
		in_data = 32'h0000_0000;
	end
	// words leave in queue order: cmd a, cmd b, body, filler
	always @(posedge hclk) begin
		if (!hresetn) begin
			in_valid <= 1'b0;
		end else if (!in_valid || in_ready) begin
			if (q.size() && $urandom % 4) begin
				in_valid <= 1'b1;
				in_data <= q.pop_front();
			end else begin
				in_valid <= 1'b0;
				in_data <= ~in_data;
			end
		end
	end
endmodule // host_writer

// ### verification/test_tx_command_a_decoder.sv
module test_tx_command_a_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, out_ready = 0, rd_ph = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, in_data, out_data, rq[$];
	logic [1:0] htrans = 0;
	logic hreadyout, hresp, in_valid, in_ready, out_valid, out_last, irq;
	logic [3:0] out_be;
	logic [36:0] exp[$];
	int err_total = 0, cmp_count = 0, cyc = 0;
	////////////////////
	tx_command_a_decoder DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .in_valid, .in_data, .in_ready, .out_valid, .out_data, .out_be,
		.out_last, .out_ready, .irq);
	host_writer u_host (.hclk, .hresetn, .in_ready, .in_valid, .in_data);
	initial forever #10 hclk = ~hclk;
	////////////////////
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp_out(logic [36:0] g, e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_rd(logic [31:0] g, e);
		cmp_out({5'h00, g}, {5'h00, e});
	endtask
	task automatic ahb(logic w, logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(logic [31:0] a, e);
		rq.push_back(e);
		ahb(0, a, 0);
	endtask
	task automatic irq_is(logic e);
		@(negedge hclk);
		cmp_rd({31'h0000_0000, irq}, {31'h0000_0000, e});
		@(posedge hclk);
	endtask
	task automatic tx_buf(logic ioc, logic [1:0] al, int ofs, int sz);
		int dw, tot, n;
		logic [31:0] w;
		logic [3:0] be;
		dw = sz ? (ofs + sz + 3) / 4 : 0;
		tot = al == 2'h1 ? (dw + 3) / 4 * 4 : al == 2'h2 ? (dw + 7) / 8 * 8 : dw;
		u_host.q.push_back({ioc, 5'h00, al, 3'h0, ofs[4:0], 5'h00, sz[10:0]});
		u_host.q.push_back($urandom);
		for (int i = 0; i < tot; i++) begin
			w = $urandom;
			u_host.q.push_back(w);
			be = 4'hF;
			if (i == ofs / 4) be = be << ofs % 4;
			if (i == dw - 1) be = be & (4'hF >> (3 - (ofs + sz - 1) % 4));
			if (i >= ofs / 4 && i < dw) exp.push_back({be, i == dw - 1, w});
		end
		n = 0;
		while ((exp.size() || u_host.q.size() || in_valid) && n++ < 3000) @(posedge hclk);
		repeat (2) @(posedge hclk);
	endtask
	////////////////////
	always @(posedge hclk) begin
		if (rd_ph) cmp_rd(hrdata, rq.pop_front());
		rd_ph <= hsel && htrans == 2'h2 && !hwrite;
		if (out_valid && out_ready) cmp_out({out_be, out_last, out_data}, exp.pop_front());
		out_ready <= $urandom % 3 != 0;
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	initial begin
		void'($urandom(53));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(32'h0000_000C, 32'h0000_0001);
		rd(32'h0000_0008, 32'h0000_0000);
		rd(32'h0000_0000, 32'h0000_0000);
		rd(32'h0000_0020, 32'h0000_0000);
		ahb(1, 32'h0000_0008, 32'h0000_0003);
		tx_buf(1, 2'h1, 5, 6);
		rd(32'h0000_0000, 32'h0000_0001);
		irq_is(1);
		ahb(1, 32'h0000_0004, 32'h0000_0003);
		irq_is(0);
		for (int k = 0; k < 9; k++) tx_buf(0, k % 3, $urandom % 32, k ? $urandom % 40 + 1 : 0);
		rd(32'h0000_0000, 32'h0000_0000);
		tx_buf(0, 2'h3, 3, 9);
		rd(32'h0000_0000, 32'h0000_0002);
		rd(32'h0000_0010, 32'h0303_0009);
		rd(32'h0000_0014, 32'h0000_0403);
		ahb(1, 32'h0000_0048, 32'h0000_0000);
		rd(32'h0000_0008, 32'h0000_0003);
		irq_is(1);
		ahb(1, 32'h0000_0008, 32'h0000_0000);
		irq_is(0);
		results();
	end
endmodule // test_tx_command_a_decoder
bind tx_command_a_decoder tx_command_a_decoder_monitor u_mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hrdata,
	.hreadyout, .hresp, .in_valid, .in_ready, .out_valid, .out_data, .out_be, .out_last, .out_ready, .irq);
